/* verilog/mdr_pkg.sv */
// Package with register map, reset values and carrier types for mdr.
package mdr_pkg;
  // Register byte offsets on the Wishbone bus.
  localparam logic [7:0] HOLD_OFS = 8'h00;
  localparam logic [7:0] UNIT_OFS = 8'h04;
  localparam logic [7:0] FILT_OFS = 8'h08;
  localparam logic [7:0] MODE_OFS = 8'h0C;
  localparam logic [7:0] WIN_OFS = 8'h10;
  localparam logic [7:0] INFN_OFS = 8'h14;
  localparam logic [7:0] ININV_OFS = 8'h30;
  localparam logic [7:0] OUTFN_OFS = 8'h4C;
  localparam logic [7:0] OUTINV_OFS = 8'h54;
  localparam logic [7:0] CFG_OFS = 8'h5C;
  localparam logic [7:0] STAT_OFS = 8'h60;
  // Values after reset and write limits.
  localparam logic [8:0] WIN_RST = 9'h0C8;
  localparam logic [8:0] WIN_MIN = 9'h001;
  localparam logic [8:0] WIN_MAX = 9'h190;
  localparam logic [1:0] FILT_MAX = 2'h2;
  localparam logic [2:0] MODE_MAX = 3'h5;
  localparam logic [6:0][7:0] INFN_RST =
    {8'h49, 8'h08, 8'h41, 8'h40, 8'h48, 8'h3B, 8'h3A};
  localparam logic [1:0][7:0] OUTFN_RST = {8'h82, 8'h93};
  // Input function codes.
  localparam logic [7:0] FN_ALM_RST = 8'h08;
  localparam logic [7:0] FN_FWD = 8'h3A;
  localparam logic [7:0] FN_REV = 8'h3B;
  localparam logic [7:0] FN_SEL0 = 8'h40;
  localparam logic [7:0] FN_DIR = 8'h48;
  localparam logic [7:0] FN_BRK_FREE = 8'h49;
  localparam logic [7:0] FN_HOLD_FREE = 8'h4A;
  // Output function codes.
  localparam logic [7:0] OF_ALARM = 8'h82;
  localparam logic [7:0] OF_MOVE = 8'h86;
  localparam logic [7:0] OF_INFO = 8'h87;
  localparam logic [7:0] OF_TLC = 8'h8C;
  localparam logic [7:0] OF_REACHED = 8'h8D;
  localparam logic [7:0] OF_SPEED = 8'h93;
  localparam logic [7:0] OF_DIR = 8'h94;
  // Holding figures: shaft displacement in degrees, torque in percent.
  localparam logic [7:0] HOLD_ANGLE_DEG = 8'h0F;
  localparam logic [7:0] HOLD_TORQUE_PCT = 8'h32;
  // Run-input wiring mode codes.
  typedef enum logic [2:0] {
    WIRE2_M1, WIRE3_M1, WIRE2_M2, WIRE2_M3, WIRE3_M2, WIRE3_M3
  } mdr_mode_e;
  // Run command driven to the motor control.
  typedef enum logic [1:0] {RUN_STOP, RUN_FWD, RUN_REV} mdr_run_e;
  // Internal status signals that output terminals can select.
  typedef struct packed {
    logic alarm;
    logic move;
    logic info;
    logic tlc;
    logic speed_pulse;
    logic dir;
  } mdr_stat_s;
  // Decoded input functions.
  typedef struct packed {
    logic alm_rst;
    logic [3:0] data_sel;
    logic brk_free;
    logic hold_free;
  } mdr_infn_s;
endpackage : mdr_pkg

/* verilog/mdr_io_ramp_cfg.sv */
// Operation and I/O configuration block of the motor driver.
// Operation
// R1: Hold setting 1 makes standstill holding torque.
// R2: Holding force starts at 15 degree displacement.
// R3: Holding torque capped by selected torque limit.
// R4: Brake released while holding, engaged without power.
// R5: Class B after stop, class C after configuration.
// R6: Unit 0 means ramp time per 3000 r/min.
// R7: Unit 1 relative, except modes 3 and 5.
// R8: Softening filter selects none, filter 1, 2.
// R9: Wiring mode codes 0 to 5 decoded.
// R10: Two-wire variant decides both-inputs-active response.
// R11: Three-wire variant decides direction change response.
// R12: Speed reached within window of commanded speed.
// R13: Window accepts 1 to 400, default 200.
// R14: Seven input terminals carry function codes.
// R15: Per-input inversion before function decoding.
// R16: Two output terminals carry function codes.
// R17: Per-output inversion drives complement.
// R18: Terminal settings apply after configuration only.
// R19: Class A settings apply immediately.
// R20: Three-wire modes reinterpret run input codes.
// R21: Old value held until update condition.
`timescale 1ns/1ns
module mdr_io_ramp_cfg (
  // Clock, reset and clock enable.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Terminal pins.
  input wire logic [6:0] in_term_i,
  output logic [1:0] out_term_o,
  // Motor state from the speed loop.
  input wire logic [15:0] motor_speed_i,
  input wire logic [15:0] cmd_speed_i,
  input wire logic motor_stopped_i,
  input wire logic [7:0] shaft_dev_deg_i,
  input wire logic [7:0] torque_limit_i,
  input wire logic digital_speed_i,
  input wire logic main_power_i,
  input wire logic brake_fitted_i,
  input wire mdr_pkg::mdr_stat_s stat_i,
  // Control outputs.
  output mdr_pkg::mdr_run_e run_o,
  output mdr_pkg::mdr_infn_s infn_o,
  output logic speed_reached_o,
  output logic hold_torque_en_o,
  output logic [7:0] hold_torque_lim_o,
  output logic brake_release_o,
  output logic ramp_rel_o,
  output logic [1:0] filter_sel_o
);

  // All state of the block.
  typedef struct packed {
    logic hold_p;
    logic hold_a;
    logic unit;
    logic [1:0] filt_p;
    logic [1:0] filt_a;
    logic [2:0] mode_p;
    logic [2:0] mode_a;
    logic [8:0] win;
    logic [6:0][7:0] infn_p;
    logic [6:0][7:0] infn_a;
    logic [6:0] ininv_p;
    logic [6:0] ininv_a;
    logic [1:0][7:0] outfn_p;
    logic [1:0][7:0] outfn_a;
    logic [1:0] outinv_p;
    logic [1:0] outinv_a;
    logic ack;
    logic [31:0] rdat;
    logic [6:0] sync1;
    logic [6:0] sync2;
    logic [1:0] run;
    logic dir_prev;
    logic held;
    logic [1:0] out_term;
    logic reached;
  } mdr_state_s;

  mdr_state_s st_r;
  mdr_state_s st_nxt;

  logic [6:0] lvl;
  logic forward_run_input;
  logic reverse_run_input;
  logic dirin;
  logic three_wire;
  logic [16:0] diff;
  logic req;
  logic [31:0] rd;
  logic [31:0] wmask;
  logic [31:0] wv;
  logic [7:0] idx;
  logic cfg_go;

  // True when any terminal carries the given code and is active.
  function automatic logic fn_hit(input logic [6:0][7:0] fn,
                                  input logic [6:0] lv,
                                  input logic [7:0] code);
    logic hit;
    hit = 1'b0;
    for (int t = 0; t < 7; t++)
    begin
      hit = hit | ((fn[t] == code) & lv[t]);
    end
    return hit;
  endfunction : fn_hit

  // Selects the internal signal named by an output function code.
  function automatic logic out_sel(input logic [7:0] code,
                                   input mdr_pkg::mdr_stat_s s,
                                   input logic at_speed);
    logic v;
    v = 1'b0;
    unique case (code)
      mdr_pkg::OF_ALARM: v = s.alarm;
      mdr_pkg::OF_MOVE: v = s.move;
      mdr_pkg::OF_INFO: v = s.info;
      mdr_pkg::OF_TLC: v = s.tlc;
      mdr_pkg::OF_REACHED: v = at_speed;
      mdr_pkg::OF_SPEED: v = s.speed_pulse;
      mdr_pkg::OF_DIR: v = s.dir;
      default: v = 1'b0;
    endcase
    return v;
  endfunction : out_sel

  // Terminal levels after inversion and function decoding.
  always_comb
  begin
    lvl = st_r.sync2 ^ st_r.ininv_a; // R15
    forward_run_input = fn_hit(st_r.infn_a, lvl, mdr_pkg::FN_FWD); // R14
    reverse_run_input = fn_hit(st_r.infn_a, lvl, mdr_pkg::FN_REV);
    dirin = fn_hit(st_r.infn_a, lvl, mdr_pkg::FN_DIR);
    three_wire = (st_r.mode_a == 3'(mdr_pkg::WIRE3_M1)) ||
                 (st_r.mode_a == 3'(mdr_pkg::WIRE3_M2)) ||
                 (st_r.mode_a == 3'(mdr_pkg::WIRE3_M3)); // R9
    infn_o.alm_rst = fn_hit(st_r.infn_a, lvl, mdr_pkg::FN_ALM_RST);
    for (int b = 0; b < 4; b++)
    begin
      infn_o.data_sel[b] = fn_hit(st_r.infn_a, lvl,
                                  mdr_pkg::FN_SEL0 + 8'(b));
    end
    infn_o.brk_free = fn_hit(st_r.infn_a, lvl, mdr_pkg::FN_BRK_FREE);
    infn_o.hold_free = fn_hit(st_r.infn_a, lvl, mdr_pkg::FN_HOLD_FREE);
  end

  // Register read mux; unmapped words read as zero.
  always_comb
  begin
    idx = 8'h00;
    rd = 32'h0000_0000;
    unique case (adr_i[7:2])
      mdr_pkg::HOLD_OFS[7:2]: rd = {31'h0, st_r.hold_p};
      mdr_pkg::UNIT_OFS[7:2]: rd = {31'h0, st_r.unit};
      mdr_pkg::FILT_OFS[7:2]: rd = {30'h0, st_r.filt_p};
      mdr_pkg::MODE_OFS[7:2]: rd = {29'h0, st_r.mode_p};
      mdr_pkg::WIN_OFS[7:2]: rd = {23'h0, st_r.win};
      mdr_pkg::OUTFN_OFS[7:2]: rd = {24'h0, st_r.outfn_p[0]};
      mdr_pkg::OUTINV_OFS[7:2]: rd = {31'h0, st_r.outinv_p[0]};
      mdr_pkg::STAT_OFS[7:2]:
        rd = {25'h0, st_r.run, st_r.out_term, st_r.reached,
              st_r.filt_a != st_r.filt_p,
              (st_r.hold_a != st_r.hold_p) || (st_r.mode_a != st_r.mode_p)
              || (st_r.infn_a != st_r.infn_p)
              || (st_r.ininv_a != st_r.ininv_p)
              || (st_r.outfn_a != st_r.outfn_p)
              || (st_r.outinv_a != st_r.outinv_p)};
      default:
      begin
        idx = 8'((adr_i - mdr_pkg::INFN_OFS) >> 2);
        if (adr_i >= mdr_pkg::INFN_OFS && adr_i < mdr_pkg::ININV_OFS)
        begin
          rd = {24'h0, st_r.infn_p[idx[2:0]]};
        end
        else if (adr_i >= mdr_pkg::ININV_OFS &&
                 adr_i < mdr_pkg::OUTFN_OFS)
        begin
          idx = 8'((adr_i - mdr_pkg::ININV_OFS) >> 2);
          rd = {31'h0, st_r.ininv_p[idx[2:0]]};
        end
        else if (adr_i == mdr_pkg::OUTFN_OFS + 8'h04)
        begin
          rd = {24'h0, st_r.outfn_p[1]};
        end
        else if (adr_i == mdr_pkg::OUTINV_OFS + 8'h04)
        begin
          rd = {31'h0, st_r.outinv_p[1]};
        end
      end
    endcase
    for (int b = 0; b < 4; b++)
    begin
      wmask[b*8 +: 8] = {8{sel_i[b]}};
    end
    wv = (rd & ~wmask) | (dat_i & wmask);
  end

  // Next state: bus, deferred updates, run decode and outputs.
  always_comb
  begin
    st_nxt = st_r;
    req = cyc_i & stb_i & ~st_r.ack;
    cfg_go = 1'b0;
    diff = 17'h00000;
    st_nxt.ack = req;
    st_nxt.rdat = req ? rd : st_r.rdat;
    st_nxt.sync1 = in_term_i;
    st_nxt.sync2 = st_r.sync1;
    if (req && we_i)
    begin
      if (adr_i == mdr_pkg::HOLD_OFS)
      begin
        st_nxt.hold_p = wv[0];
      end
      if (adr_i == mdr_pkg::UNIT_OFS)
      begin
        st_nxt.unit = wv[0]; // R19
      end
      if (adr_i == mdr_pkg::FILT_OFS && wv[31:2] == 30'h0 &&
          wv[1:0] <= mdr_pkg::FILT_MAX)
      begin
        st_nxt.filt_p = wv[1:0]; // R8
      end
      if (adr_i == mdr_pkg::MODE_OFS && wv[31:3] == 29'h0 &&
          wv[2:0] <= mdr_pkg::MODE_MAX)
      begin
        st_nxt.mode_p = wv[2:0]; // R9
      end
      if (adr_i == mdr_pkg::WIN_OFS && wv[31:9] == 23'h0 &&
          wv[8:0] >= mdr_pkg::WIN_MIN && wv[8:0] <= mdr_pkg::WIN_MAX)
      begin
        st_nxt.win = wv[8:0]; // R13 R19
      end
      if (adr_i >= mdr_pkg::INFN_OFS && adr_i < mdr_pkg::ININV_OFS)
      begin
        st_nxt.infn_p[idx[2:0]] = wv[7:0];
      end
      if (adr_i >= mdr_pkg::ININV_OFS && adr_i < mdr_pkg::OUTFN_OFS)
      begin
        st_nxt.ininv_p[idx[2:0]] = wv[0];
      end
      // Each output pair is two words four bytes apart, as on reads.
      if (adr_i == mdr_pkg::OUTFN_OFS)
      begin
        st_nxt.outfn_p[0] = wv[7:0];
      end
      if (adr_i == mdr_pkg::OUTFN_OFS + 8'h04)
      begin
        st_nxt.outfn_p[1] = wv[7:0];
      end
      if (adr_i == mdr_pkg::OUTINV_OFS)
      begin
        st_nxt.outinv_p[0] = wv[0];
      end
      if (adr_i == mdr_pkg::OUTINV_OFS + 8'h04)
      begin
        st_nxt.outinv_p[1] = wv[0];
      end
      cfg_go = (adr_i == mdr_pkg::CFG_OFS) && wv[0];
    end
    // Class B waits for standstill so a filter never switches mid-ramp.
    if (motor_stopped_i)
    begin
      st_nxt.filt_a = st_r.filt_p; // R5 R21
    end
    // Class C settings move together on a configuration command.
    if (cfg_go)
    begin
      st_nxt.hold_a = st_r.hold_p; // R5 R21
      st_nxt.mode_a = st_r.mode_p;
      st_nxt.infn_a = st_r.infn_p; // R18
      st_nxt.ininv_a = st_r.ininv_p;
      st_nxt.outfn_a = st_r.outfn_p;
      st_nxt.outinv_a = st_r.outinv_p;
    end
    // Run decode. Three-wire: start input runs, run/brake low stops.
    st_nxt.dir_prev = dirin;
    // A direction stop lasts until start or run/brake drops.
    // Without it the motor would restart on the very next cycle.
    st_nxt.held = st_r.held & three_wire;
    if (three_wire)
    begin
      if (!forward_run_input || !reverse_run_input)
      begin
        st_nxt.run = 2'(mdr_pkg::RUN_STOP); // R20
        st_nxt.held = 1'b0;
      end
      else if (st_r.held)
      begin
        st_nxt.run = 2'(mdr_pkg::RUN_STOP);
      end
      else if (st_r.run == 2'(mdr_pkg::RUN_STOP))
      begin
        st_nxt.run = dirin ? 2'(mdr_pkg::RUN_REV) : 2'(mdr_pkg::RUN_FWD);
      end
      else if (dirin != st_r.dir_prev)
      begin
        // Mode 1 reverses at once, mode 2 stops, mode 3 waits.
        unique case (st_r.mode_a)
          3'(mdr_pkg::WIRE3_M1):
          begin
            st_nxt.run = dirin ? 2'(mdr_pkg::RUN_REV)
                               : 2'(mdr_pkg::RUN_FWD); // R11
          end
          3'(mdr_pkg::WIRE3_M2):
          begin
            st_nxt.run = 2'(mdr_pkg::RUN_STOP);
            st_nxt.held = 1'b1;
          end
          default: st_nxt.run = st_r.run;
        endcase
      end
    end
    else if (forward_run_input && reverse_run_input)
    begin
      // Mode 1 stops, mode 2 keeps the last command, mode 3 runs fwd.
      unique case (st_r.mode_a)
        3'(mdr_pkg::WIRE2_M1): st_nxt.run = 2'(mdr_pkg::RUN_STOP); // R10
        3'(mdr_pkg::WIRE2_M2): st_nxt.run = st_r.run;
        default: st_nxt.run = 2'(mdr_pkg::RUN_FWD);
      endcase
    end
    else
    begin
      st_nxt.run = forward_run_input ? 2'(mdr_pkg::RUN_FWD) :
                   reverse_run_input ? 2'(mdr_pkg::RUN_REV) : 2'(mdr_pkg::RUN_STOP);
    end
    // Speed reached window around the commanded speed.
    diff = (motor_speed_i >= cmd_speed_i) ?
           17'(motor_speed_i - cmd_speed_i) :
           17'(cmd_speed_i - motor_speed_i);
    st_nxt.reached = (diff <= 17'(st_r.win)); // R12
    for (int o = 0; o < 2; o++)
    begin
      st_nxt.out_term[o] = out_sel(st_r.outfn_a[o], stat_i,
                                   st_r.reached) ^ st_r.outinv_a[o]; // R16 R17
    end
    if (!ce_i)
    begin
      st_nxt = st_r;
    end
  end

  // State register; reset plays the role of a power cycle.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r <= '0;
      st_r.win <= mdr_pkg::WIN_RST; // R13
      st_r.infn_p <= mdr_pkg::INFN_RST; // R14
      st_r.infn_a <= mdr_pkg::INFN_RST;
      st_r.outfn_p <= mdr_pkg::OUTFN_RST; // R16
      st_r.outfn_a <= mdr_pkg::OUTFN_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Holding: only at standstill, once the shaft is pushed far enough.
  // Heat rises with holding load, so torque never exceeds the cap.
  assign hold_torque_en_o = st_r.hold_a & motor_stopped_i &
    (shaft_dev_deg_i >= mdr_pkg::HOLD_ANGLE_DEG); // R1 R2
  assign hold_torque_lim_o =
    (torque_limit_i < mdr_pkg::HOLD_TORQUE_PCT) ?
    torque_limit_i : mdr_pkg::HOLD_TORQUE_PCT; // R3
  // Brake stays open while powered and holding or running.
  assign brake_release_o = brake_fitted_i & main_power_i &
    (st_r.hold_a | (st_r.run != 2'(mdr_pkg::RUN_STOP))); // R4
  // Relative ramp only for digital speed and not modes 3 or 5.
  assign ramp_rel_o = st_r.unit & digital_speed_i &
    (st_r.mode_a != 3'(mdr_pkg::WIRE2_M3)) &
    (st_r.mode_a != 3'(mdr_pkg::WIRE3_M3)); // R6 R7
  assign filter_sel_o = st_r.filt_a; // R8
  assign run_o = mdr_pkg::mdr_run_e'(st_r.run);
  assign speed_reached_o = st_r.reached;
  assign out_term_o = st_r.out_term;
  assign dat_o = st_r.rdat;
  assign ack_o = st_r.ack;

endmodule : mdr_io_ramp_cfg

/* verification/mdr_ctrl_model.sv */
// Behavioural model of the controller that drives the input terminals.
`timescale 1ns/1ns
module mdr_ctrl_model (
  // Clock.
  input wire logic clk_i,
  // Requested levels and pace.
  input wire logic slow_i,
  input wire logic [6:0] want_i,
  // Terminal pins toward the driver.
  output logic [6:0] pins_o = 7'h00
);
  logic [6:0] lag_r = 7'h00;
  // A slow controller moves its pins one clock later than a prompt one.
  always @(posedge clk_i)
  begin
    lag_r <= want_i;
    pins_o <= slow_i ? lag_r : want_i;
  end
endmodule : mdr_ctrl_model

/* verification/mdr_asserts.sv */
// Concurrent checks on the motor driver configuration block.
`timescale 1ns/1ns
module mdr_chk (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus handshake.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  // Motor state.
  input wire logic [15:0] motor_speed_i,
  input wire logic [15:0] cmd_speed_i,
  input wire logic motor_stopped_i,
  input wire logic [7:0] shaft_dev_deg_i,
  input wire logic [7:0] torque_limit_i,
  input wire logic digital_speed_i,
  input wire logic main_power_i,
  // Watched outputs.
  input wire logic speed_reached_o,
  input wire logic hold_torque_en_o,
  input wire logic [7:0] hold_torque_lim_o,
  input wire logic brake_release_o,
  input wire logic ramp_rel_o,
  input wire logic [1:0] filter_sel_o
);
  logic [15:0] gap;
  // Speed error of either sign, so one window compare covers both.
  assign gap = (motor_speed_i > cmd_speed_i) ?
    motor_speed_i - cmd_speed_i : cmd_speed_i - motor_speed_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("bus request not answered in one cycle");
  chk_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("acknowledge longer than one cycle");
  chk_hold_cause: assert property (hold_torque_en_o |->
    motor_stopped_i && shaft_dev_deg_i >= 8'h0F)
    else $error("holding torque without standstill deviation");
  chk_torque_cap: assert property (hold_torque_lim_o ==
    (torque_limit_i < 8'h32 ? torque_limit_i : 8'h32))
    else $error("holding torque limit wrong");
  chk_brake_power: assert property (!main_power_i |-> !brake_release_o)
    else $error("brake released without main power");
  chk_filter_stop: assert property (!$stable(filter_sel_o) &&
    !$past(rst_i) |-> $past(motor_stopped_i))
    else $error("filter changed while running");
  chk_filter_range: assert property (filter_sel_o <= 2'h2)
    else $error("filter selection out of range");
  chk_ramp_digital: assert property (ramp_rel_o |-> digital_speed_i)
    else $error("relative ramp without digital speed");
  chk_reached_far: assert property ($past(gap > 16'h0190) |->
    !speed_reached_o)
    else $error("reached flagged outside any window");
  chk_reached_near: assert property ($past(gap == 16'h0000 && !rst_i) |->
    speed_reached_o)
    else $error("reached missing at exact speed");
  cover property (ack_o);
  cover property (hold_torque_en_o);
  cover property (!$stable(filter_sel_o));
endmodule : mdr_chk
bind mdr_io_ramp_cfg mdr_chk u_chk (.clk_i, .rst_i, .cyc_i, .stb_i,
  .ack_o, .motor_speed_i, .cmd_speed_i, .motor_stopped_i, .shaft_dev_deg_i,
  .torque_limit_i, .digital_speed_i, .main_power_i, .speed_reached_o,
  .hold_torque_en_o, .hold_torque_lim_o, .brake_release_o, .ramp_rel_o,
  .filter_sel_o);

/* verification/testbench.sv */
// Self-checking bench for the motor driver configuration block.
`timescale 1ns/1ns
module testbench;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, slow = 0;
  logic halt = 1, dig = 0, pwr = 1, brk = 1, sr, hen, brel, rrel;
  logic [7:0] adr = 0, tl = 0, dev = 0, hl;
  logic [31:0] dat = 0, q, dq;
  logic [15:0] ms = 0, cs = 0;
  logic [6:0] want = 0, pins;
  logic [1:0] ot, fs;
  mdr_pkg::mdr_stat_s st = '0;
  mdr_pkg::mdr_run_e run, r0;
  mdr_pkg::mdr_infn_s inf;
  int error_cnt = 0, n_checks = 0, cyc_cnt = 0;
  // Clock of 4 ns period.
  always #2 clk_i = ~clk_i;
  mdr_ctrl_model PM (.clk_i, .slow_i(slow), .want_i(want), .pins_o(pins));
  mdr_io_ramp_cfg DUT (.clk_i, .rst_i, .ce_i(1'b1), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat),
    .dat_o(q), .ack_o(ack), .in_term_i(pins), .out_term_o(ot),
    .motor_speed_i(ms), .cmd_speed_i(cs), .motor_stopped_i(halt),
    .shaft_dev_deg_i(dev), .torque_limit_i(tl), .digital_speed_i(dig),
    .main_power_i(pwr), .brake_fitted_i(brk), .stat_i(st), .run_o(run),
    .infn_o(inf), .speed_reached_o(sr), .hold_torque_en_o(hen),
    .hold_torque_lim_o(hl), .brake_release_o(brel), .ramp_rel_o(rrel),
    .filter_sel_o(fs));
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  // One classic cycle; the request holds until ack is seen at an edge.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1)
      @(posedge clk_i);
    dq = q;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic settle();
    repeat (8) @(posedge clk_i);
  endtask : settle
  task automatic mode(input logic [31:0] m);
    wb(1, mdr_pkg::MODE_OFS, m);
    wb(1, mdr_pkg::CFG_OFS, 32'h1);
  endtask : mode
  // Start in a three-wire mode, then flip the direction pin.
  task automatic run3(input logic [31:0] m);
    want <= 7'h00;
    mode(m);
    want <= 7'h03;
    settle();
    r0 = run;
    chk(r0 !== mdr_pkg::RUN_STOP, 1);
    want <= 7'h07;
    settle();
  endtask : run3
  function automatic logic [31:0] fact(input int i);
    if (i == 4)
      return 32'(mdr_pkg::WIN_RST);
    if (i >= 5 && i < 12)
      return 32'(mdr_pkg::INFN_RST[i - 5]);
    if (i == 19 || i == 20)
      return 32'(mdr_pkg::OUTFN_RST[i - 19]);
    return 32'h0;
  endfunction : fact
  // Cut a hang short; the run needs well under a thousand cycles.
  always @(posedge clk_i)
  begin
    cyc_cnt++;
    if (cyc_cnt == 5000)
    begin
      error_cnt++;
      stop_test();
    end
  end
  // Main sequence.
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 23; i++)
    begin
      wb(0, 8'(i * 4), 32'h0);
      chk(dq, fact(i));
    end
    wb(0, 8'h80, 32'h0);
    chk(dq, 32'h0);
    // Window bounds, applied at once, with the speed error at 400.
    wb(1, mdr_pkg::WIN_OFS, 32'h0);
    wb(1, mdr_pkg::WIN_OFS, 32'h191);
    wb(0, mdr_pkg::WIN_OFS, 32'h0);
    chk(dq, 32'hC8);
    cs <= 16'h03E8;
    ms <= 16'h0578;
    wb(1, mdr_pkg::WIN_OFS, 32'h190);
    settle();
    chk(sr, 1'b1);
    ms <= 16'h0579;
    settle();
    chk(sr, 1'b0);
    ms <= 16'h0578;
    wb(1, mdr_pkg::WIN_OFS, 32'h18F);
    settle();
    chk(sr, 1'b0);
    // The filter waits for standstill; an illegal code is ignored.
    halt <= 1'b0;
    wb(1, mdr_pkg::FILT_OFS, 32'h2);
    wb(1, mdr_pkg::FILT_OFS, 32'h3);
    wb(0, mdr_pkg::FILT_OFS, 32'h0);
    chk(dq, 32'h2);
    chk(fs, 2'h0);
    halt <= 1'b1;
    settle();
    chk(fs, 2'h2);
    // Ramp unit is applied at once but needs digital speed.
    dig <= 1'b1;
    settle();
    chk(rrel, 1'b0);
    dig <= 1'b0;
    wb(1, mdr_pkg::UNIT_OFS, 32'h1);
    chk(rrel, 1'b0);
    dig <= 1'b1;
    settle();
    chk(rrel, 1'b1);
    // Two-wire modes with both run pins active.
    want <= 7'h03;
    settle();
    chk(run, mdr_pkg::RUN_STOP);
    wb(1, mdr_pkg::MODE_OFS, 32'h3);
    settle();
    chk(run, mdr_pkg::RUN_STOP);
    wb(1, mdr_pkg::CFG_OFS, 32'h1);
    settle();
    chk(run, mdr_pkg::RUN_FWD);
    want <= 7'h00;
    mode(32'h2);
    want <= 7'h02;
    settle();
    want <= 7'h03;
    settle();
    chk(run, mdr_pkg::RUN_REV);
    // Three-wire modes, all with a slow controller.
    slow <= 1'b1;
    run3(32'h1);
    chk(run, r0 == mdr_pkg::RUN_FWD ? mdr_pkg::RUN_REV
                                    : mdr_pkg::RUN_FWD);
    run3(32'h4);
    chk(run, mdr_pkg::RUN_STOP);
    run3(32'h5);
    chk(run, r0);
    chk(rrel, 1'b0);
    // Inverted input terminal 0 runs forward with all pins low.
    want <= 7'h00;
    wb(1, mdr_pkg::ININV_OFS, 32'h1);
    mode(32'h0);
    settle();
    chk(run, mdr_pkg::RUN_FWD);
    // Terminal 3 selects data bit 0 and terminal 5 resets alarms.
    want <= 7'h28;
    settle();
    chk(inf, 32'h44);
    // Output terminals: factory codes, then reached inverted.
    st.speed_pulse <= 1'b1;
    settle();
    chk(ot, 2'h1);
    st <= '0;
    wb(1, mdr_pkg::OUTFN_OFS, 32'h8D);
    wb(1, mdr_pkg::OUTINV_OFS, 32'h1);
    settle();
    chk(ot, 2'h0);
    wb(1, mdr_pkg::CFG_OFS, 32'h1);
    settle();
    chk(ot, 2'h1);
    ms <= 16'h03E8;
    settle();
    chk(ot, 2'h0);
    // Standstill holding with brake and torque cap.
    dev <= 8'h0F;
    tl <= 8'h1E;
    settle();
    chk(hen, 1'b0);
    wb(1, mdr_pkg::HOLD_OFS, 32'h1);
    wb(1, mdr_pkg::CFG_OFS, 32'h1);
    settle();
    chk({hen, brel, hl}, {2'h3, 8'h1E});
    dev <= 8'h0E;
    tl <= 8'h50;
    pwr <= 1'b0;
    settle();
    chk({hen, brel, hl}, {2'h0, 8'h32});
    stop_test();
  end
endmodule : testbench
